// ### hw/coproc_bus_host.sv
// Coprocessor-side bus controller sitting on the processor's local bus
//
// Notes on behaviour
// - With 8-bit boot memory, assert byte bus size while boot select active.
// - Coprocessor ready reaches processor only through buffer gated by local access.
// - Low status select follows memory/IO; high status select follows bit 23.
// - Command/data select comes from bit 2; 8000FEH acts as 8000FCH.
// - Status enable held high permanently.
// - Clock mode held high for synchronous operation.
// - Processor and coprocessor share one clock and reset.
// - Busy, error and operand request connect one to one.
// - Software sets math-present and clears emulation in core control word.
// - Coprocessor sits on the processor's local address and data bus.
//
// Local design decisions: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
module coproc_bus_host (
    // Clock and reset, shared with the processor
    input  wire logic        core_clk_in,
    input  wire logic        rst_in,
    // Software register port
    input  wire logic [3:0]  reg_addr_in,
    input  wire logic [15:0] reg_wdata_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    output logic [15:0]      reg_rdata_out,
    // Processor local bus, observed
    input  wire logic        ads_n_in,
    input  wire logic [23:1] addr_in,
    input  wire logic        m_io_in,
    input  wire logic        w_r_in,
    input  wire logic        local_bus_access_n_in,
    input  wire logic        boot_region_select_n_in,
    input  wire logic [15:0] data_in,
    // Processor local bus, driven
    output logic [15:0]      data_out,
    output logic             data_oe_out,
    output logic             ready_n_out,
    output logic             ready_oe_out,
    output logic             byte_bus_size_n_out,
    // Coprocessor straps and handshake
    output logic             status_enable_in_out,
    output logic             clock_mode_select_out,
    output logic             busy_n_out,
    output logic             error_n_out,
    output logic             operand_transfer_request_out,
    // Core configuration image for the boot code
    output logic [15:0]      core_control_out,
    output logic             pin_route_out
);

    // Coprocessor is selected when memory/IO is low and bit 23 is high
    function automatic logic coproc_select(input logic m_io, input logic a23);
        coproc_select = !m_io && a23;
    endfunction

    // Address check against the three legal port addresses
    function automatic logic legal_port(input logic [23:1] a);
        logic [23:0] full;
        full = {a, 1'b0};
        legal_port = (full == coproc_host_pkg::CMD_ADDR) || (full == coproc_host_pkg::DATA_ADDR) ||
                     (full == coproc_host_pkg::DATA_ALT_ADDR);
    endfunction

    coproc_host_pkg::cycle_state_t state_reg, state_next;
    logic        is_write_reg,   is_write_next;
    logic        is_data_reg,    is_data_next;
    logic        timer_start;
    logic        timer_expired;
    logic        ready_n_reg,    ready_n_next;
    logic        ready_oe_reg,   ready_oe_next;
    logic [15:0] dout_reg,       dout_next;
    logic        dout_oe_reg,    dout_oe_next;

    logic [3:0]  ctrl_reg,       ctrl_next;
    logic [15:0] msw_reg,        msw_next;
    logic [15:0] command_reg,    command_next;
    logic [7:0]  busy_cnt_reg,   busy_cnt_next;
    logic        stray_reg,      stray_next;
    logic        done_reg,       done_next;
    logic [1:0]  wr_ptr_reg,     wr_ptr_next;
    logic [1:0]  rd_ptr_reg,     rd_ptr_next;
    logic [15:0] operand_mem [coproc_host_pkg::OPERAND_DEPTH];
    logic        mem_we;
    logic [15:0] rdata_reg,      rdata_next;
    logic        bs8_n_reg,      bs8_n_next;
    logic        busy_n_reg,     busy_n_next;
    logic        error_n_reg,    error_n_next;
    logic        opreq_reg,      opreq_next;

    logic        cycle_hit;
    logic        sw_stray_clear;

    // A new coprocessor cycle starts on the address strobe with the selects matched
    assign cycle_hit = !ads_n_in && coproc_select(m_io_in, addr_in[coproc_host_pkg::STATUS_HIGH_BIT]);
    assign sw_stray_clear = reg_wr_in && (reg_addr_in == coproc_host_pkg::OFF_STATUS) &&
                            reg_wdata_in[coproc_host_pkg::STAT_STRAY_POS];

    coproc_wait_timer u_wait (
        .core_clk_in (core_clk_in),
        .rst_in      (rst_in),
        .start_in    (timer_start),
        .expired_out (timer_expired)
    );

    // Bus cycle sequencing and the buffered ready answer
    always_comb begin
        state_next    = state_reg;
        is_write_next = is_write_reg;
        is_data_next  = is_data_reg;
        timer_start   = 1'b0;
        ready_n_next  = 1'b1;
        ready_oe_next = 1'b0;
        dout_next     = dout_reg;
        dout_oe_next  = 1'b0;
        unique case (state_reg)
            coproc_host_pkg::ST_IDLE: begin
                if (cycle_hit) begin
                    is_write_next = w_r_in;
                    is_data_next  = addr_in[coproc_host_pkg::CMD_SEL_BIT];
                    timer_start   = 1'b1;
                    state_next    = coproc_host_pkg::ST_WAIT;
                end
            end
            coproc_host_pkg::ST_WAIT: begin
                // Drive ready only while the processor has released local access
                if (timer_expired && local_bus_access_n_in) begin
                    ready_n_next  = 1'b0;
                    ready_oe_next = 1'b1;
                    dout_next     = operand_mem[rd_ptr_reg];
                    dout_oe_next  = !is_write_reg && is_data_reg;
                    state_next    = coproc_host_pkg::ST_DONE;
                end else if (timer_expired) begin
                    // Processor still owns ready; restart the wait timer and retry when it expires, the cycle stays open
                    timer_start = 1'b1;
                end
            end
            coproc_host_pkg::ST_DONE: begin
                state_next = coproc_host_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            state_reg    <= coproc_host_pkg::ST_IDLE;
            is_write_reg <= 1'b0;
            is_data_reg  <= 1'b0;
            ready_n_reg  <= 1'b1;
            ready_oe_reg <= 1'b0;
            dout_reg     <= 16'h0000;
            dout_oe_reg  <= 1'b0;
        end else begin
            state_reg    <= state_next;
            is_write_reg <= is_write_next;
            is_data_reg  <= is_data_next;
            ready_n_reg  <= ready_n_next;
            ready_oe_reg <= ready_oe_next;
            dout_reg     <= dout_next;
            dout_oe_reg  <= dout_oe_next;
        end
    end

    // Command, operand and handshake state of the coprocessor end
    always_comb begin
        command_next  = command_reg;
        busy_cnt_next = busy_cnt_reg;
        wr_ptr_next   = wr_ptr_reg;
        rd_ptr_next   = rd_ptr_reg;
        stray_next    = stray_reg;
        done_next     = done_reg;
        mem_we        = 1'b0;
        if (busy_cnt_reg != 8'h00) begin
            busy_cnt_next = busy_cnt_reg - 8'h01;
            done_next     = (busy_cnt_reg == 8'h01) ? 1'b1 : done_reg;
        end
        if (state_reg == coproc_host_pkg::ST_DONE) begin
            if (is_write_reg && !is_data_reg) begin
                command_next  = data_in;
                busy_cnt_next = coproc_host_pkg::BUSY_COUNT;
                done_next     = 1'b0;
                wr_ptr_next   = 2'b00;
                rd_ptr_next   = 2'b00;
            end else if (is_write_reg) begin
                mem_we      = 1'b1;
                wr_ptr_next = wr_ptr_reg + 2'b01;
            end else if (is_data_reg) begin
                rd_ptr_next = rd_ptr_reg + 2'b01;
            end
        end
        // Stray address is sticky; a new hit wins over a software clear
        if (sw_stray_clear) begin
            stray_next = 1'b0;
        end
        if (cycle_hit && state_reg == coproc_host_pkg::ST_IDLE && !legal_port(addr_in)) begin
            stray_next = 1'b1;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            command_reg  <= 16'h0000;
            busy_cnt_reg <= 8'h00;
            wr_ptr_reg   <= 2'b00;
            rd_ptr_reg   <= 2'b00;
            stray_reg    <= 1'b0;
            done_reg     <= 1'b0;
        end else begin
            command_reg  <= command_next;
            busy_cnt_reg <= busy_cnt_next;
            wr_ptr_reg   <= wr_ptr_next;
            rd_ptr_reg   <= rd_ptr_next;
            stray_reg    <= stray_next;
            done_reg     <= done_next;
        end
    end

    // Operand store, written from the local data bus
    always_ff @(posedge core_clk_in) begin
        if (mem_we) begin
            operand_mem[wr_ptr_reg] <= data_in;
        end
    end

    // Software registers and registered pin outputs
    always_comb begin
        ctrl_next    = ctrl_reg;
        msw_next     = msw_reg;
        rdata_next   = 16'h0000;
        if (reg_wr_in && reg_addr_in == coproc_host_pkg::OFF_CTRL) begin
            ctrl_next = reg_wdata_in[3:0];
        end
        if (reg_wr_in && reg_addr_in == coproc_host_pkg::OFF_MSW) begin
            msw_next = reg_wdata_in;
        end
        // Enabling the coprocessor forces the core word to math-present, no emulation
        if (ctrl_reg[coproc_host_pkg::CTRL_ENABLE_POS]) begin
            msw_next = (msw_next | coproc_host_pkg::MATH_PRESENT_VAL) &
                       ~(16'h0001 << coproc_host_pkg::EMULATION_POS);
        end
        if (reg_rd_in) begin
            unique case (reg_addr_in)
                coproc_host_pkg::OFF_CTRL:    rdata_next = {12'h000, ctrl_reg};
                coproc_host_pkg::OFF_STATUS:  rdata_next = {13'h0, done_reg, stray_reg, !busy_n_reg};
                coproc_host_pkg::OFF_COMMAND: rdata_next = command_reg;
                coproc_host_pkg::OFF_MSW:     rdata_next = msw_reg;
                coproc_host_pkg::OFF_OPERAND: rdata_next = operand_mem[rd_ptr_reg];
                default:                      rdata_next = 16'h0000;
            endcase
        end
        // Boot memory is byte wide while the boot8 bit is set, until the reprogram bit is set
        bs8_n_next   = !(!boot_region_select_n_in && ctrl_reg[coproc_host_pkg::CTRL_BOOT8_POS] &&
                         !ctrl_reg[coproc_host_pkg::CTRL_REPROG_POS]);
        busy_n_next  = !(busy_cnt_next != 8'h00);
        error_n_next = !ctrl_reg[coproc_host_pkg::CTRL_ERROR_POS];
        opreq_next   = (busy_cnt_next != 8'h00) && command_reg[0];
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            ctrl_reg    <= coproc_host_pkg::CTRL_RESET;
            msw_reg     <= coproc_host_pkg::MSW_RESET;
            rdata_reg   <= 16'h0000;
            bs8_n_reg   <= 1'b1;
            busy_n_reg  <= 1'b1;
            error_n_reg <= 1'b1;
            opreq_reg   <= 1'b0;
        end else begin
            ctrl_reg    <= ctrl_next;
            msw_reg     <= msw_next;
            rdata_reg   <= rdata_next;
            bs8_n_reg   <= bs8_n_next;
            busy_n_reg  <= busy_n_next;
            error_n_reg <= error_n_next;
            opreq_reg   <= opreq_next;
        end
    end

    // Output assignments straight from flip-flops; straps come from unreset flops loaded with constants every clock
    logic strap_reg;
    logic route_reg;
    always_ff @(posedge core_clk_in) begin
        strap_reg <= 1'b1;
        route_reg <= 1'b0;
    end

    assign reg_rdata_out                = rdata_reg;
    assign data_out                     = dout_reg;
    assign data_oe_out                  = dout_oe_reg;
    assign ready_n_out                  = ready_n_reg;
    assign ready_oe_out                 = ready_oe_reg;
    assign byte_bus_size_n_out          = bs8_n_reg;
    assign status_enable_in_out         = strap_reg;
    assign clock_mode_select_out        = strap_reg;
    assign busy_n_out                   = busy_n_reg;
    assign error_n_out                  = error_n_reg;
    assign operand_transfer_request_out = opreq_reg;
    assign core_control_out             = msw_reg;
    assign pin_route_out                = route_reg;

    // Checks on the bus answer and handshake
    int wait_len;
    always_ff @(posedge core_clk_in) begin
        if (rst_in || state_reg != coproc_host_pkg::ST_WAIT) begin
            wait_len <= 0;
        end else begin
            wait_len <= wait_len + 1;
        end
    end

    chk_ready_gated: assert property (@(posedge core_clk_in) disable iff (rst_in)
        ready_oe_out |-> $past(local_bus_access_n_in)) else $error("ready driven while local access held");
    chk_ready_pair: assert property (@(posedge core_clk_in) disable iff (rst_in)
        ready_oe_out == !ready_n_out) else $error("ready level without enable");
    chk_ready_once: assert property (@(posedge core_clk_in) disable iff (rst_in)
        !ready_n_out |=> ready_n_out) else $error("ready held more than one cycle");
    chk_ready_follows_hit: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (cycle_hit && state_reg == coproc_host_pkg::ST_IDLE) ##1 local_bus_access_n_in [*3]
        |=> !ready_n_out) else $error("ready not answered after wait states");
    chk_no_spurious_ready: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (state_reg == coproc_host_pkg::ST_IDLE && !cycle_hit) |=> ready_n_out) else $error("ready without select");
    chk_byte_size: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (!boot_region_select_n_in && ctrl_reg[0] && !ctrl_reg[1]) |=> !byte_bus_size_n_out)
        else $error("byte bus size missing on boot select");
    chk_byte_idle: assert property (@(posedge core_clk_in) disable iff (rst_in)
        boot_region_select_n_in |=> byte_bus_size_n_out) else $error("byte bus size without boot select");
    chk_straps_high: assert property (@(posedge core_clk_in) disable iff (rst_in)
        ##1 (status_enable_in_out && clock_mode_select_out)) else $error("strap not high");
    chk_busy_after_cmd: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (state_reg == coproc_host_pkg::ST_DONE && is_write_reg && !is_data_reg) |=> !busy_n_out [*8])
        else $error("busy not held after command");
    chk_msw_enable: assert property (@(posedge core_clk_in) disable iff (rst_in)
        ctrl_reg[3] |=> (core_control_out[1] && !core_control_out[2])) else $error("control word not enabled");
    chk_stray_sticky: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (cycle_hit && state_reg == coproc_host_pkg::ST_IDLE && !legal_port(addr_in)) |=> stray_reg)
        else $error("stray address not flagged");
    chk_wait_bound: assert property (@(posedge core_clk_in) disable iff (rst_in)
        wait_len < 200) else $error("coprocessor cycle stuck");

    cov_cmd_write: cover property (@(posedge core_clk_in) disable iff (rst_in)
        state_reg == coproc_host_pkg::ST_DONE && is_write_reg && !is_data_reg);
    cov_data_read: cover property (@(posedge core_clk_in) disable iff (rst_in)
        data_oe_out && !ready_n_out);
    cov_ready_retry: cover property (@(posedge core_clk_in) disable iff (rst_in)
        timer_expired && !local_bus_access_n_in && state_reg == coproc_host_pkg::ST_WAIT);

endmodule

// ### hw/coproc_host_pkg.sv
// Constants shared by the coprocessor-side bus controller and its wait-state timer
package coproc_host_pkg;

    // Coprocessor port addresses seen on the processor's local bus
    localparam logic [23:0] CMD_ADDR      = 24'h8000f8;
    localparam logic [23:0] DATA_ADDR     = 24'h8000fc;
    localparam logic [23:0] DATA_ALT_ADDR = 24'h8000fe;

    // Address bit positions used for strapping the selects
    localparam int unsigned STATUS_HIGH_BIT = 23;
    localparam int unsigned CMD_SEL_BIT     = 2;

    // Core control word fields and the pin routing field
    localparam int unsigned MATH_PRESENT_POS = 1;
    localparam int unsigned EMULATION_POS    = 2;
    localparam int unsigned PIN_ROUTE_POS    = 5;
    localparam logic [15:0] MATH_PRESENT_VAL = 16'h0002;

    // Software register offsets
    localparam logic [3:0] OFF_CTRL    = 4'h0;
    localparam logic [3:0] OFF_STATUS  = 4'h1;
    localparam logic [3:0] OFF_COMMAND = 4'h2;
    localparam logic [3:0] OFF_MSW     = 4'h3;
    localparam logic [3:0] OFF_OPERAND = 4'h4;

    // Control register fields
    localparam int unsigned CTRL_BOOT8_POS  = 0;
    localparam int unsigned CTRL_REPROG_POS = 1;
    localparam int unsigned CTRL_ERROR_POS  = 2;
    localparam int unsigned CTRL_ENABLE_POS = 3;

    // Status register fields
    localparam int unsigned STAT_BUSY_POS  = 0;
    localparam int unsigned STAT_STRAY_POS = 1;
    localparam int unsigned STAT_DONE_POS  = 2;

    // Reset values
    localparam logic [3:0]  CTRL_RESET = 4'h1;
    localparam logic [15:0] MSW_RESET  = 16'h0000;

    // Cycle counts
    localparam logic [3:0] WAIT_COUNT = 4'h2;
    localparam logic [7:0] BUSY_COUNT = 8'h10;

    // Operand store depth
    localparam int unsigned OPERAND_DEPTH = 4;

    // Bus cycle states, Gray coded
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT = 2'b01,
        ST_DONE = 2'b11
    } cycle_state_t;

endpackage

// ### hw/coproc_wait_timer.sv
// Wait-state timer that paces the coprocessor's ready answer
`timescale 1ns/10ps
module coproc_wait_timer (
    // Clock and reset
    input  wire logic       core_clk_in,
    input  wire logic       rst_in,
    // Control
    input  wire logic       start_in,
    output logic            expired_out
);

    logic [3:0] count_reg;
    logic [3:0] count_next;
    logic       run_reg;
    logic       run_next;
    logic       expired_reg;
    logic       expired_next;

    // Count down the programmed wait states after a start
    always_comb begin
        count_next   = count_reg;
        run_next     = run_reg;
        expired_next = 1'b0;
        if (start_in) begin
            count_next = coproc_host_pkg::WAIT_COUNT;
            run_next   = 1'b1;
        end else if (run_reg) begin
            if (count_reg == 4'h1) begin
                run_next     = 1'b0;
                expired_next = 1'b1;
            end
            count_next = count_reg - 4'h1;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            count_reg   <= 4'h0;
            run_reg     <= 1'b0;
            expired_reg <= 1'b0;
        end else begin
            count_reg   <= count_next;
            run_reg     <= run_next;
            expired_reg <= expired_next;
        end
    end

    assign expired_out = expired_reg;

endmodule

// ### verif/cpu_bus_model.sv
// Processor-side model that runs coprocessor cycles on the shared local bus
`timescale 1ns/10ps
module cpu_bus_model (
    // Clock shared with the controller
    input  wire logic        core_clk_in,
    // Local bus driven by the processor
    output logic             ads_n_out,
    output logic [23:1]      addr_out,
    output logic             m_io_out,
    output logic             w_r_out,
    output logic             local_bus_access_n_out,
    output logic [15:0]      data_out,
    // Answers seen on the bus
    input  wire logic [15:0] data_in,
    input  wire logic        ready_n_in,
    input  wire logic        ready_oe_in
);
    // Idle bus: internal cycles keep local access asserted
    initial begin
        ads_n_out = 1'b1;
        addr_out = '0;
        m_io_out = 1'b1;
        w_r_out = 1'b0;
        local_bus_access_n_out = 1'b0;
        data_out = 16'h5a5a;
    end

    // One cycle; lba_wait delays the release of local access to test retries
    task automatic cyc(input logic [23:0] a, input logic io, input logic wr, input logic [15:0] d,
                       input int lba_wait, output logic ok, output logic [15:0] q);
        int n;
        ok = 1'b0;
        q = '0;
        n = 0;
        @(posedge core_clk_in);
        ads_n_out <= 1'b0;
        addr_out <= a[23:1];
        m_io_out <= io;
        w_r_out <= wr;
        data_out <= d;
        local_bus_access_n_out <= (lba_wait == 0);
        while (!ok && n < 40) begin
            @(posedge core_clk_in);
            ads_n_out <= 1'b1;
            ok = ready_oe_in && !ready_n_in;
            q = data_in;
            n++;
            if (!ok && n < 40) begin
                local_bus_access_n_out <= (n >= lba_wait);
            end
        end
        // Release right after the edge that saw ready; the controller took the data there
        data_out <= ~d;
        local_bus_access_n_out <= 1'b0;
        m_io_out <= 1'b1;
    endtask
endmodule

// ### verif/tb_coproc_bus_host.sv
// Self-checking bench for the coprocessor-side bus controller
`timescale 1ns/10ps
module tb_coproc_bus_host;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [3:0]  ra = '0;
    logic [15:0] wd = '0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        boot_n = 1'b1;
    logic [15:0] seed = 16'he6cd;
    logic [15:0] q, v, cmd;
    logic        ok;
    logic [15:0] exp_q[$];
    int          err_total = 0;
    int          checks_done = 0;
    wire logic        ads_n, m_io, w_r, lba_n, oe, rdy_n, rdy_oe, bs8_n, status_enable_in, clock_mode_select, busy_n, err_n, opreq, route;
    wire logic [23:1] addr;
    wire logic [15:0] cpu_d, dq, rdata, core_ctl;
    wire logic [15:0] bus_d = oe ? dq : cpu_d;

    // Clock at 20 MHz
    always #25 clk = ~clk;

    coproc_bus_host coproc_bus_host_inst (.core_clk_in(clk), .rst_in(rst), .reg_addr_in(ra),
        .reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .ads_n_in(ads_n),
        .addr_in(addr), .m_io_in(m_io), .w_r_in(w_r), .local_bus_access_n_in(lba_n),
        .boot_region_select_n_in(boot_n), .data_in(bus_d), .data_out(dq), .data_oe_out(oe),
        .ready_n_out(rdy_n), .ready_oe_out(rdy_oe), .byte_bus_size_n_out(bs8_n),
        .status_enable_in_out(status_enable_in), .clock_mode_select_out(clock_mode_select), .busy_n_out(busy_n),
        .error_n_out(err_n), .operand_transfer_request_out(opreq), .core_control_out(core_ctl),
        .pin_route_out(route));
    cpu_bus_model cpu_bus_model_inst (.core_clk_in(clk), .ads_n_out(ads_n), .addr_out(addr),
        .m_io_out(m_io), .w_r_out(w_r), .local_bus_access_n_out(lba_n), .data_out(cpu_d),
        .data_in(bus_d), .ready_n_in(rdy_n), .ready_oe_in(rdy_oe));

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
        checks_done++;
        if (g !== e) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        ra <= a;
        wd <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk);
        ra <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Buffered ready must never be enabled while the processor owns ready
    always @(posedge clk) begin
        if (!rst && rdy_oe && !lba_n) begin
            err_total++;
            $display("BAD ready_buffer expected 0 seen 1");
        end
    end

    // Watchdog sized well beyond the roughly two hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        report_and_stop();
    end

    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1 chk("straps", 16'h00dc, {8'h00, status_enable_in, clock_mode_select, route, busy_n, err_n, bs8_n, rdy_oe, opreq});
        rd_reg(coproc_host_pkg::OFF_CTRL, q);
        chk("ctrl_reset", 16'h0001, q);
        rd_reg(coproc_host_pkg::OFF_MSW, q);
        chk("msw_reset", 16'h0000, q);
        rd_reg(4'hf, q);
        chk("unmapped", 16'h0000, q);
        $display("test reset done");
        boot_n <= 1'b0;
        repeat (3) @(posedge clk);
        #1 chk("byte_size_boot", 16'h0000, {15'h0, bs8_n});
        wr_reg(coproc_host_pkg::OFF_CTRL, 16'h0003);
        repeat (3) @(posedge clk);
        #1 chk("byte_size_reprog", 16'h0001, {15'h0, bs8_n});
        boot_n <= 1'b1;
        wr_reg(coproc_host_pkg::OFF_CTRL, 16'h0009);
        $display("test boot width done");
        seed = lfsr(seed);
        cpu_bus_model_inst.cyc(coproc_host_pkg::DATA_ADDR, 1'b0, 1'b1, seed, 6, ok, q);
        chk("late_lba_ready", 16'h0001, {15'h0, ok});
        seed = lfsr(seed);
        cmd = {seed[15:1], 1'b1};
        cpu_bus_model_inst.cyc(coproc_host_pkg::CMD_ADDR, 1'b0, 1'b1, cmd, 0, ok, q);
        repeat (2) @(posedge clk);
        #1 chk("busy_opreq", 16'h0001, {14'h0, busy_n, opreq});
        rd_reg(coproc_host_pkg::OFF_COMMAND, q);
        chk("command", cmd, q);
        for (int i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            exp_q.push_back(seed);
            v = seed;
            cpu_bus_model_inst.cyc(i[0] ? coproc_host_pkg::DATA_ALT_ADDR : coproc_host_pkg::DATA_ADDR,
                                   1'b0, 1'b1, v, 0, ok, q);
        end
        for (int i = 0; i < 4; i++) begin
            cpu_bus_model_inst.cyc(i[0] ? coproc_host_pkg::DATA_ADDR : coproc_host_pkg::DATA_ALT_ADDR,
                                   1'b0, 1'b0, 16'h0000, 0, ok, q);
            chk("operand", exp_q.pop_front(), q);
        end
        repeat (20) @(posedge clk);
        #1 chk("busy_end", 16'h0001, {15'h0, busy_n});
        rd_reg(coproc_host_pkg::OFF_STATUS, q);
        chk("status_done", 16'h0004, q);
        $display("test operands done");
        wr_reg(coproc_host_pkg::OFF_MSW, 16'h0005);
        rd_reg(coproc_host_pkg::OFF_MSW, q);
        chk("msw", 16'h0003, q);
        chk("core_control", 16'h0003, core_ctl);
        wr_reg(coproc_host_pkg::OFF_CTRL, 16'h000d);
        repeat (2) @(posedge clk);
        #1 chk("error_on", 16'h0000, {15'h0, err_n});
        wr_reg(coproc_host_pkg::OFF_CTRL, 16'h0009);
        repeat (2) @(posedge clk);
        #1 chk("error_off", 16'h0001, {15'h0, err_n});
        $display("test control done");
        cpu_bus_model_inst.cyc(24'h8000f0, 1'b0, 1'b1, 16'h0000, 0, ok, q);
        rd_reg(coproc_host_pkg::OFF_STATUS, q);
        chk("stray_set", 16'h0002, q & 16'h0002);
        wr_reg(coproc_host_pkg::OFF_STATUS, 16'h0002);
        rd_reg(coproc_host_pkg::OFF_STATUS, q);
        chk("stray_clear", 16'h0000, q & 16'h0002);
        cpu_bus_model_inst.cyc(coproc_host_pkg::CMD_ADDR, 1'b1, 1'b1, 16'h0000, 0, ok, q);
        chk("memory_cycle_ignored", 16'h0000, {15'h0, ok});
        $display("test address decode done");
        report_and_stop();
    end
endmodule
